// ==== clear_contacts.sv ====
// Model of the external clear contacts on the rear connector
`timescale 1ns/100ps
module clear_contacts (
    input  wire logic [2:0] press,       // Contact closed, one per clear input
    output wire logic       primary_n,   // Primary clear line
    output wire logic       secondary_n, // Secondary clear line
    output wire logic       tertiary_n   // Tertiary clear line
);
    // A closed contact pulls its line low, the pull-up holds it high otherwise
    assign {tertiary_n, secondary_n, primary_n} = ~press;
endmodule

// ==== clear_input_cond.v ====
// Conditions one active-low clear input into an edge or level request
`timescale 1ns/100ps
`include "reset_stop_defines.vh"
module clear_input_cond (
    input  wire clk_sys,       // System clock
    input  wire rst,           // Synchronous reset, active high
    input  wire clear_n,       // Raw clear input, active low
    input  wire trigger_level, // 1 selects level mode
    output reg  request_ff     // Registered request
);
    reg sync1_ff;
    reg sync2_ff;
    reg prev_ff;
    // Two-stage synchroniser plus history for edge detection
    always @(posedge clk_sys) begin
        if (rst) begin
            sync1_ff   <= 1'b0;
            sync2_ff   <= 1'b0;
            prev_ff    <= 1'b0;
            request_ff <= 1'b0;
        end else begin
            sync1_ff   <= ~clear_n;
            sync2_ff   <= sync1_ff;
            prev_ff    <= sync2_ff;
            if (trigger_level == `TRIG_LEVEL)
                request_ff <= sync2_ff;
            else
                request_ff <= sync2_ff & ~prev_ff;
        end
    end
endmodule

// ==== halt_hold_timer.v ====
// Counts the hold-off time after a stop before a second press may resume
`timescale 1ns/100ps
`include "reset_stop_defines.vh"
module halt_hold_timer #(
    parameter HOLD_CYC = `HALT_HOLD_CYC // Hold-off in clock cycles
) (
    input  wire clk_sys, // System clock
    input  wire rst,     // Synchronous reset, active high
    input  wire start,   // Pulse: begin the hold-off
    input  wire abort,   // Pulse: cancel the hold-off
    output reg  done_ff  // High once the hold-off has passed
);
    reg [31:0] count_ff;
    // Down-counter with sticky done flag
    always @(posedge clk_sys) begin
        if (rst || abort) begin
            count_ff <= 32'h0000_0000;
            done_ff  <= 1'b0;
        end else if (start) begin
            count_ff <= HOLD_CYC;
            done_ff  <= 1'b0;
        end else if (count_ff > 32'h0000_0001) begin
            count_ff <= count_ff - 32'h0000_0001;
        end else if (count_ff == 32'h0000_0001) begin
            count_ff <= 32'h0000_0000;
            done_ff  <= 1'b1;
        end
    end
endmodule

// ==== meter_reset_stop_control.v ====
// Reset, clear and stop control for the flow meter
//
// Overview of operation
// - On power restore, copy stored settings to working memory, clear measurements.
// - Configuration reload clears measurements except time, then resumes run mode.
// - Reload on double reset press in configuration, or after last parameter saved.
// - Lockout bit 1 keeps setpoints in working memory only; 0 permits storing.
// - Reset after setpoint change while locked returns to run, shows not-saved message.
// - Primary clear is edge-triggered when select is 0, level when 1.
// - Rate or square-root mode: primary clear zeroes the total counter.
// - Rate mode: primary clear unlatches total alarm when both latch bits set.
// - Clear ends a pulsed alarm only if that setpoint has no pulse duration.
// - Rate mode: secondary clear restarts mean, unlatches setpoint 3 and 4 alarms.
// - Rate or square-root mode: secondary clear restarts hysteresis: below uses setpoint 3, above setpoint 4.
// - Rate or square-root mode: tertiary clear loads time from time preset.
// - Panel reset dispatched by displayed value unless disabled or configuring.
// - Batch mode: primary clear reloads batch with 0 or setpoint 3, increments lot.
// - Batch mode: external primary clear unlatches batch alarm if both latch bits set, cancels stop halt.
// - Batch mode: secondary clear sets lot to 0 or setpoint 4, unlatches lot alarms.
// - Batch mode: tertiary zeroes total, unlatches; loads time only if panel enabled.
// - Batch mode panel reset: preload batch, lot action, zero total, or time preset.
// - Auto clear enabled: internal primary clear reloads batch by count direction.
// - Batch mode: stop button forces setpoints active; second press after 3 s clears, resumes.
`timescale 1ns/100ps
`include "reset_stop_defines.vh"
module meter_reset_stop_control #(
    parameter W        = 32,             // Measurement word width
    parameter HOLD_CYC = `HALT_HOLD_CYC  // Stop re-press hold-off in cycles
) (
    input  wire         clk_sys,               // System clock, 50 MHz
    input  wire         rst,                   // Synchronous reset, active high
    input  wire         power_restored,        // Pulse: power has come back
    input  wire [1:0]   run_mode,              // Rate, square-root or batch
    input  wire [1:0]   display_sel,           // Displayed measurement
    input  wire         configuring,           // Configuration menu active
    input  wire         config_last_saved,     // Pulse: final parameter saved
    input  wire         setpoint_changed,      // Pulse: setpoint edited
    input  wire         panel_reset,           // Pulse: front reset button
    input  wire         stop_button,           // Pulse: front stop button
    input  wire         ext_stop,              // Pulse: external stop input
    input  wire         primary_clear_input_n, // Primary clear, active low
    input  wire         secondary_clear_input_n, // Secondary clear, active low
    input  wire         tertiary_clear_input_n,  // Tertiary clear, active low
    input  wire         clear_trigger_select,  // 0 edge, 1 level
    input  wire         latch_enable_bit_a,    // Latch enable, first bit
    input  wire         latch_enable_bit_b,    // Latch enable, second bit
    input  wire         panel_clear_disable,   // 1 disables panel reset dispatch
    input  wire         batch_direction,       // 1 batch counts down
    input  wire         lot_counter_direction, // 1 lot counts down
    input  wire         auto_clear_enable,     // 1 enables autoreset
    input  wire         auto_clear_trigger,    // Pulse: autoreset setpoint hit
    input  wire         halt_button_enable,    // 1 enables stop button
    input  wire         nv_store_lockout,      // 1 blocks nonvolatile store
    input  wire [4:0]   pulse_timed,           // Setpoint has a pulse duration
    input  wire         rate_alarm_below,      // Rate alarm active below
    input  wire [W-1:0] setpoint3_value,       // Setpoint 3 value
    input  wire [W-1:0] setpoint4_value,       // Setpoint 4 value
    input  wire [W-1:0] time_preset,           // Elapsed time preset
    input  wire [W-1:0] batch_preload_value,   // Batch panel preload
    input  wire [W-1:0] latest_rate,           // Latest rate sample
    input  wire [W-1:0] lot_count_in,          // Present lot count
    output reg          nv_load_ff,            // Copy stored settings to working
    output reg          nv_store_ff,           // Write setpoints to storage
    output reg          not_saved_message_ff,  // Show not-saved indication
    output reg          run_mode_enter_ff,     // Return to run mode
    output reg          clear_all_meas_ff,     // Clear all measurements
    output reg          clear_meas_keep_time_ff, // Clear all but elapsed time
    output reg          total_clear_ff,        // Zero total counter
    output reg          time_load_ff,          // Load elapsed time
    output reg  [W-1:0] time_value_ff,         // Value for time load
    output reg          mean_restart_ff,       // Load mean flow rate
    output reg  [W-1:0] mean_flow_rate_ff,     // New mean flow rate
    output reg          hyst_restart_ff,       // Restart rate hysteresis
    output reg  [2:0]   hyst_setpoint_ff,      // Setpoint used for hysteresis
    output reg          batch_load_ff,         // Load batch counter
    output reg  [W-1:0] batch_value_ff,        // Value for batch load
    output reg          lot_load_ff,           // Load lot count
    output reg  [W-1:0] lot_count_ff,          // Value for lot load
    output reg  [4:0]   unlatch_ff,            // Unlatch alarm per setpoint
    output reg  [4:0]   pulse_end_ff,          // End pulsed alarm per setpoint
    output reg          force_active_ff,       // Force all setpoints active
    output reg          halted_ff,             // Stop halt in force
    output reg          clear_alarms_ff        // Clear every alarm
);
    // Stop control states
    localparam ST_RUN  = 2'b00;
    localparam ST_HALT = 2'b01;

    wire req_a_ext;
    wire req_b_ext;
    wire req_c_ext;
    wire hold_done;
    reg  [1:0] stop_state_ff;
    reg  [1:0] nxt_stop_state;
    reg        cfg_press_ff;
    reg        sp_dirty_ff;
    reg        hold_start;
    reg        hold_abort;

    // Setpoints on total: 1,2 in rate modes; batch: 1..3; lot: 4; time: 5
    function [4:0] pulse_mask;
        input [4:0] sel;
        input [4:0] timed;
        begin
            pulse_mask = sel & ~timed;
        end
    endfunction

    // Input conditioning, one per external clear
    clear_input_cond u_cond_a (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .clear_n       (primary_clear_input_n),
        .trigger_level (clear_trigger_select),
        .request_ff    (req_a_ext)
    );
    clear_input_cond u_cond_b (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .clear_n       (secondary_clear_input_n),
        .trigger_level (clear_trigger_select),
        .request_ff    (req_b_ext)
    );
    clear_input_cond u_cond_c (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .clear_n       (tertiary_clear_input_n),
        .trigger_level (clear_trigger_select),
        .request_ff    (req_c_ext)
    );

    halt_hold_timer #(
        .HOLD_CYC (HOLD_CYC)
    ) u_hold (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (hold_start),
        .abort   (hold_abort),
        .done_ff (hold_done)
    );

    wire is_batch = (run_mode == `MODE_BATCH);
    wire is_rate  = (run_mode == `MODE_RATE);
    wire panel_ok = panel_reset & ~panel_clear_disable & ~configuring;

    // Panel dispatch by displayed measurement
    wire pan_rate  = panel_ok & ~is_batch & (display_sel == `DISP_RATE);
    wire pan_avg   = panel_ok & ~is_batch & (display_sel == `DISP_AVG);
    wire pan_total = panel_ok & (display_sel == `DISP_TOTAL);
    wire pan_time  = panel_ok & (display_sel == `DISP_TIME);
    wire pan_batch = panel_ok & is_batch & (display_sel == `DISP_BATCH);
    wire pan_lot   = panel_ok & is_batch & (display_sel == `DISP_LOT);

    // Merged action requests, one action however many sources
    wire act_a = req_a_ext | (pan_total & ~is_batch) |
                 (is_batch & auto_clear_enable & auto_clear_trigger);
    wire act_b = req_b_ext | pan_rate | pan_lot;
    wire act_c = req_c_ext | (pan_time & ~is_batch);
    wire mean_new = (req_b_ext & ~is_batch) | pan_avg;
    // Unlatching on a primary clear needs both latch enable bits
    wire latch_on = latch_enable_bit_a & latch_enable_bit_b;

    // Pulsed alarms a clear may end, those without a pulse duration
    wire [4:0] end_total = pulse_mask(5'h03, pulse_timed);
    wire [4:0] end_rate  = pulse_mask(5'h0C, pulse_timed);
    wire [4:0] end_batch = pulse_mask(5'h07, pulse_timed);

    // Configuration reload, power-on load and setpoint storage
    always @(posedge clk_sys) begin
        if (rst) begin
            nv_load_ff              <= 1'b0;
            nv_store_ff             <= 1'b0;
            not_saved_message_ff    <= 1'b0;
            run_mode_enter_ff       <= 1'b0;
            clear_all_meas_ff       <= 1'b0;
            clear_meas_keep_time_ff <= 1'b0;
            cfg_press_ff            <= 1'b0;
            sp_dirty_ff             <= 1'b0;
        end else begin
            nv_load_ff              <= 1'b0;
            nv_store_ff             <= 1'b0;
            run_mode_enter_ff       <= 1'b0;
            clear_all_meas_ff       <= 1'b0;
            clear_meas_keep_time_ff <= 1'b0;
            if (!configuring)
                cfg_press_ff <= 1'b0;
            // Power restore outranks a reload, a reload outranks storage
            if (power_restored) begin
                nv_load_ff        <= 1'b1;
                clear_all_meas_ff <= 1'b1;
                run_mode_enter_ff <= 1'b1;
                sp_dirty_ff       <= 1'b0;
            end else if (configuring &&
                         (config_last_saved || (panel_reset && cfg_press_ff))) begin
                nv_load_ff              <= 1'b1;
                clear_meas_keep_time_ff <= 1'b1;
                run_mode_enter_ff       <= 1'b1;
                cfg_press_ff            <= 1'b0;
            end else if (configuring && panel_reset) begin
                cfg_press_ff <= 1'b1;
            end else if (setpoint_changed) begin
                sp_dirty_ff          <= 1'b1;
                not_saved_message_ff <= 1'b0;
                nv_store_ff          <= ~nv_store_lockout;
            end else if (panel_reset && sp_dirty_ff) begin
                sp_dirty_ff       <= 1'b0;
                run_mode_enter_ff <= 1'b1;
                if (nv_store_lockout)
                    not_saved_message_ff <= 1'b1;
                else
                    nv_load_ff <= 1'b1;
            end else if (panel_reset) begin
                not_saved_message_ff <= 1'b0;
            end
        end
    end

    // Clear actions on measurements and alarms
    always @(posedge clk_sys) begin
        if (rst) begin
            total_clear_ff    <= 1'b0;
            time_load_ff      <= 1'b0;
            time_value_ff     <= `ZERO_VALUE;
            mean_restart_ff   <= 1'b0;
            mean_flow_rate_ff <= `ZERO_VALUE;
            hyst_restart_ff   <= 1'b0;
            hyst_setpoint_ff  <= 3'h0;
            batch_load_ff     <= 1'b0;
            batch_value_ff    <= `ZERO_VALUE;
            lot_load_ff       <= 1'b0;
            lot_count_ff      <= `ZERO_VALUE;
            unlatch_ff        <= 5'h00;
            pulse_end_ff      <= 5'h00;
        end else begin
            total_clear_ff  <= 1'b0;
            time_load_ff    <= 1'b0;
            mean_restart_ff <= 1'b0;
            hyst_restart_ff <= 1'b0;
            batch_load_ff   <= 1'b0;
            lot_load_ff     <= 1'b0;
            unlatch_ff      <= 5'h00;
            pulse_end_ff    <= 5'h00;
            // Time value follows the preset, so every load takes the latest one
            time_value_ff   <= time_preset;
            if (!is_batch) begin
                if (act_a) begin
                    total_clear_ff <= 1'b1;
                    if (is_rate && latch_on)
                        unlatch_ff[1:0] <= 2'b11;
                    pulse_end_ff[1:0] <= end_total[1:0];
                end
                if (act_b) begin
                    hyst_restart_ff  <= 1'b1;
                    hyst_setpoint_ff <= rate_alarm_below ? 3'h3 : 3'h4;
                    if (is_rate)
                        unlatch_ff[3:2] <= 2'b11;
                    pulse_end_ff[3:2] <= end_rate[3:2];
                end
                if (mean_new && is_rate) begin
                    mean_restart_ff   <= 1'b1;
                    mean_flow_rate_ff <= latest_rate;
                end
                if (act_c)
                    time_load_ff <= 1'b1;
            end else begin
                if (act_a) begin
                    batch_load_ff  <= 1'b1;
                    batch_value_ff <= batch_direction ? setpoint3_value : `ZERO_VALUE;
                    lot_load_ff    <= 1'b1;
                    lot_count_ff   <= lot_count_in + `LOT_STEP;
                    if (latch_on && !auto_clear_trigger)
                        unlatch_ff[2:0] <= 3'b111;
                    pulse_end_ff[2:0] <= end_batch[2:0];
                end else if (pan_batch) begin
                    batch_load_ff  <= 1'b1;
                    batch_value_ff <= batch_preload_value;
                end
                if (act_b) begin
                    lot_load_ff  <= 1'b1;
                    lot_count_ff <= lot_counter_direction ? setpoint4_value : `ZERO_VALUE;
                    unlatch_ff[3] <= 1'b1;
                    pulse_end_ff[3] <= ~pulse_timed[3];
                end
                if (req_c_ext || pan_total) begin
                    total_clear_ff <= 1'b1;
                    unlatch_ff[3]  <= 1'b1;
                end
                if ((req_c_ext && !panel_clear_disable) || pan_time)
                    time_load_ff <= 1'b1;
                if (panel_ok)
                    unlatch_ff <= 5'h1F;
            end
        end
    end

    // Stop state machine, batch mode only
    always @* begin
        nxt_stop_state = stop_state_ff;
        hold_start     = 1'b0;
        hold_abort     = 1'b0;
        case (stop_state_ff)
            ST_RUN: begin
                if (is_batch && ((stop_button && halt_button_enable) || ext_stop)) begin
                    nxt_stop_state = ST_HALT;
                    hold_start     = 1'b1;
                end
            end
            // A primary clear ends the halt at once, a stop press only after hold-off
            ST_HALT: begin
                if (is_batch && req_a_ext) begin
                    nxt_stop_state = ST_RUN;
                    hold_abort     = 1'b1;
                end else if (stop_button && hold_done) begin
                    nxt_stop_state = ST_RUN;
                    hold_abort     = 1'b1;
                end
            end
            default: begin
                nxt_stop_state = ST_RUN;
            end
        endcase
    end

    // Stop state register and its outputs
    always @(posedge clk_sys) begin
        if (rst) begin
            stop_state_ff   <= ST_RUN;
            force_active_ff <= 1'b0;
            halted_ff       <= 1'b0;
            clear_alarms_ff <= 1'b0;
        end else begin
            stop_state_ff   <= nxt_stop_state;
            force_active_ff <= (nxt_stop_state == ST_HALT);
            halted_ff       <= (nxt_stop_state == ST_HALT);
            clear_alarms_ff <= (stop_state_ff == ST_HALT) && (nxt_stop_state == ST_RUN)
                               && stop_button;
        end
    end
endmodule

// ==== reset_stop_defines.vh ====
// Constants for the meter reset and stop control block
`ifndef RESET_STOP_DEFINES_VH
`define RESET_STOP_DEFINES_VH
// Run modes
`define MODE_RATE        2'h0
`define MODE_SQRT        2'h1
`define MODE_BATCH       2'h2
// Displayed measurement selection, rate and square-root modes
`define DISP_RATE        2'h0
`define DISP_AVG         2'h1
`define DISP_TOTAL       2'h2
`define DISP_TIME        2'h3
// Displayed measurement selection, batch mode
`define DISP_BATCH       2'h0
`define DISP_LOT         2'h1
// Clear trigger select values
`define TRIG_EDGE        1'h0
`define TRIG_LEVEL       1'h1
// Reset value and lot count step
`define ZERO_VALUE       32'h0000_0000
`define LOT_STEP         32'h0000_0001
// Stop re-press hold-off time in milliseconds, and clock rate in kHz
`define HALT_HOLD_MS     3000
`define CLK_KHZ          50000
`define HALT_HOLD_CYC    (`HALT_HOLD_MS * `CLK_KHZ)
`endif

// ==== rs_monitor.sv ====
// Checker on the ports of the reset and stop control
`timescale 1ns/100ps
`include "reset_stop_defines.vh"
module rs_monitor #(parameter W = 32) (
    input wire logic clk_sys, rst, panel_reset, stop_button, configuring, rate_alarm_below,
    input wire logic primary_clear_input_n, secondary_clear_input_n, tertiary_clear_input_n,
    input wire logic clear_trigger_select, latch_enable_bit_a, latch_enable_bit_b,
    input wire logic panel_clear_disable, batch_direction, halt_button_enable, halted_ff,
    input wire logic total_clear_ff, time_load_ff, hyst_restart_ff, batch_load_ff,
    input wire logic force_active_ff, power_restored, setpoint_changed, nv_store_lockout,
    input wire logic nv_store_ff, clear_alarms_ff, mean_restart_ff,
    input wire logic [1:0] run_mode, display_sel,
    input wire logic [2:0] hyst_setpoint_ff,
    input wire logic [4:0] unlatch_ff, pulse_timed, pulse_end_ff,
    input wire logic [W-1:0] setpoint3_value, time_preset, lot_count_in, time_value_ff,
    input wire logic [W-1:0] batch_value_ff, lot_count_ff, latest_rate, mean_flow_rate_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Mode and trigger shorthands
    wire rt = run_mode == `MODE_RATE;
    wire bt = run_mode == `MODE_BATCH;
    wire eg = !clear_trigger_select;
    a_prim_total: assert property ($fell(primary_clear_input_n) && eg && rt |->
        ##4 total_clear_ff && unlatch_ff[1:0] == {2{latch_enable_bit_a & latch_enable_bit_b}}
        && pulse_end_ff[1:0] == ~pulse_timed[1:0])
        else $error("primary clear wrong");
    a_level_hold: assert property ((!eg && rt && !primary_clear_input_n)[*4]
        |-> ##1 total_clear_ff) else $error("level clear not held");
    a_edge_once: assert property ((eg && rt && !primary_clear_input_n && !panel_reset)[*6]
        |-> !total_clear_ff) else $error("edge clear repeated");
    a_hyst_pick: assert property ($fell(secondary_clear_input_n) && rt |-> ##4
        hyst_restart_ff && hyst_setpoint_ff == (rate_alarm_below ? 3'd3 : 3'd4)
        && mean_restart_ff && mean_flow_rate_ff == $past(latest_rate) && unlatch_ff[3:2] == 2'b11)
        else $error("hysteresis setpoint wrong");
    a_time_load: assert property ($fell(tertiary_clear_input_n) && !bt |-> ##4
        time_load_ff && time_value_ff == time_preset) else $error("time load wrong");
    a_batch_load: assert property ($fell(primary_clear_input_n) && eg && bt |-> ##4
        batch_load_ff && batch_value_ff == (batch_direction ? setpoint3_value : 0)
        && lot_count_ff == lot_count_in + 1) else $error("batch reload wrong");
    a_panel_total: assert property (panel_reset && !panel_clear_disable && !configuring
        && rt && display_sel == `DISP_TOTAL |-> ##[1:2] total_clear_ff) else $error("panel total");
    a_stop_force: assert property (stop_button && bt && halt_button_enable && !halted_ff
        |-> ##[1:2] force_active_ff) else $error("stop did not force");
    a_store_lock: assert property (setpoint_changed && !configuring && !power_restored |=>
        nv_store_ff == !nv_store_lockout) else $error("store lockout ignored");
    a_resume_clear: assert property ($fell(halted_ff) && $past(stop_button) |->
        clear_alarms_ff) else $error("resume did not clear alarms");
    c_batch: cover property (batch_load_ff);
    c_force: cover property (force_active_ff);
    c_hyst: cover property (hyst_restart_ff);
endmodule
bind meter_reset_stop_control rs_monitor #(.W(W)) i_mon (.*);

// ==== tb_top.sv ====
// Self-checking bench for the meter reset and stop control
`timescale 1ns/100ps
`include "reset_stop_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
    logic        clk_sys = 0, rst = 1, cfg = 0, cts = 0, pcd = 0, ace = 0, hbe = 0;
    logic        la, lb, bd, ld, nvl, blw;
    logic [6:0]  pl = 0;
    logic [2:0]  press = 0;
    logic [1:0]  md = 0, ds = 0;
    logic [4:0]  pt;
    logic [31:0] sp3 = 0, sp4 = 0, tp = 0, bpl = 0, lci = 0, lr;
    logic [39:0] e, q[$];
    integer      bad_count = 0, n_compared = 0, i;
    wire         p_n, s_n, t_n, nv, ca, kt, tc, tl, hr, bl, ll, fa, nsm;
    wire [2:0]   hs;
    wire [31:0]  tv, bv, lc;
    wire [7:0]   fl = {nv, ca, kt, tc, tl, hr, bl, ll};
    wire [31:0]  dat = (bl ? bv : 0) ^ (ll ? lc : 0) ^ (tl ? tv : 0) ^ (hr ? hs : 0);
    wire [31:0]  rf = 32'h0810_0004, bf = 32'h0810_0102;
    clear_contacts i_contacts (.press(press), .primary_n(p_n), .secondary_n(s_n),
        .tertiary_n(t_n));
    meter_reset_stop_control #(.HOLD_CYC(20)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .power_restored(pl[0]), .run_mode(md), .display_sel(ds), .configuring(cfg),
        .config_last_saved(pl[1]), .setpoint_changed(pl[5]), .panel_reset(pl[2]),
        .stop_button(pl[3]), .ext_stop(pl[6]), .primary_clear_input_n(p_n),
        .secondary_clear_input_n(s_n), .tertiary_clear_input_n(t_n), .clear_trigger_select(cts),
        .latch_enable_bit_a(la), .latch_enable_bit_b(lb), .panel_clear_disable(pcd),
        .batch_direction(bd), .lot_counter_direction(ld), .auto_clear_enable(ace),
        .auto_clear_trigger(pl[4]), .halt_button_enable(hbe), .nv_store_lockout(nvl),
        .pulse_timed(pt), .rate_alarm_below(blw), .setpoint3_value(sp3), .setpoint4_value(sp4),
        .time_preset(tp), .batch_preload_value(bpl), .latest_rate(lr), .lot_count_in(lci),
        .nv_load_ff(nv), .nv_store_ff(), .not_saved_message_ff(nsm), .run_mode_enter_ff(),
        .clear_all_meas_ff(ca), .clear_meas_keep_time_ff(kt), .total_clear_ff(tc),
        .time_load_ff(tl), .time_value_ff(tv), .mean_restart_ff(), .mean_flow_rate_ff(),
        .hyst_restart_ff(hr), .hyst_setpoint_ff(hs), .batch_load_ff(bl), .batch_value_ff(bv),
        .lot_load_ff(ll), .lot_count_ff(lc), .unlatch_ff(), .pulse_end_ff(),
        .force_active_ff(fa), .halted_ff(), .clear_alarms_ff());
    // Clock, 20 ns period
    initial forever #10 clk_sys = ~clk_sys;
    task cyc(input int n); repeat (n) @(negedge clk_sys); endtask
    task note(input [7:0] f, input [31:0] d); q.push_back({f, d}); endtask
    task pulse(input int b); pl[b] = 1; cyc(1); pl = 0; cyc(2); endtask
    task clr(input int b, input int n); press[b] = 1; cyc(n); press[b] = 0; cyc(8); endtask
    task done(input string s); cyc(4); `CHK(q.size(), 0) $display("test %s done", s); endtask
    task end_sim;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Takes the oldest note whenever an action shows
    always @(negedge clk_sys) begin
        if (!rst && fl != 0 && q.size() == 0) begin
            bad_count++;
            $display("BAD %0t action with no note", $time);
        end else if (!rst && fl != 0) begin
            e = q.pop_front();
            `CHK({fl, dat}, e)
        end
    end
    // Watchdog against a hang
    initial begin
        cyc(3000);
        bad_count++;
        end_sim;
    end
    // Main sequence
    initial begin
        void'($urandom(49216));
        {lr, pt, blw, nvl, ld, bd, lb, la} = 43'({$urandom, $urandom});
        cyc(8);
        rst = 0;
        cyc(2);
        note(8'hC0, 0);
        pulse(0);
        cfg = 1;
        note(8'hA0, 0);
        pulse(2);
        pulse(2);
        note(8'hA0, 0);
        pulse(1);
        cfg = 0;
        pcd = 1;
        if (!nvl) note(8'h80, 0);
        pulse(5);
        pulse(2);
        `CHK(nsm, nvl)
        done("power and reload");
        note(8'h10, 0);
        clr(0, 6);
        cts = 1;
        repeat (4) note(8'h10, 0);
        clr(0, 4);
        cts = 0;
        note(8'h04, blw ? 3 : 4);
        clr(1, 2);
        tp = $urandom;
        note(8'h08, tp);
        clr(2, 2);
        for (i = 0; i < 8; i++) begin
            {pcd, ds} = i[2:0];
            if (!pcd && i != 1) note(rf[8*i+:8], i == 0 ? (blw ? 3 : 4) : i == 3 ? tp : 0);
            pulse(2);
        end
        done("rate");
        md = `MODE_BATCH;
        for (i = 0; i < 2; i++) begin
            {bd, pcd} = {i[0], i[0]};
            {sp3, lci, tp} = {$urandom, $urandom, $urandom};
            note(8'h03, (bd ? sp3 : 0) ^ (lci + 1));
            clr(0, 2);
            note(pcd ? 8'h10 : 8'h18, pcd ? 0 : tp);
            clr(2, 2);
        end
        {ace, pcd} = 2'b10;
        note(8'h03, sp3 ^ (lci + 1));
        pulse(4);
        {bpl, sp4} = {$urandom, $urandom};
        for (i = 0; i < 4; i++) begin
            ds = i[1:0];
            note(bf[8*i+:8], i == 0 ? bpl : i == 1 ? (ld ? sp4 : 0) : i == 3 ? tp : 0);
            pulse(2);
        end
        done("batch");
        hbe = 1;
        pulse(3);
        `CHK(fa, 1'b1)
        cyc(25);
        pulse(3);
        `CHK(fa, 1'b0)
        pulse(6);
        `CHK(fa, 1'b1)
        note(8'h03, sp3 ^ (lci + 1));
        clr(0, 2);
        `CHK(fa, 1'b0)
        done("stop");
        end_sim;
    end
endmodule
